// ==== hdl/dbp_regs.svh ====
// Register indices, field positions, reset values and mode codes of the dual byte port pair
`ifndef DBP_REGS_SVH
`define DBP_REGS_SVH

// Register indices (Avalon word address); byte address is four times the index
`define DBP_IDX_PORT2_DIRECTION      16'hFFB1
`define DBP_IDX_PORT2_OUTPUT_LATCH   16'hFFB3
`define DBP_IDX_PORT2_PULLUP_ENABLE  16'hFFAD
`define DBP_IDX_PORT3_DIRECTION      16'hFFB4
`define DBP_IDX_PORT3_OUTPUT_LATCH   16'hFFB6
`define DBP_IDX_PORT3_PULLUP_ENABLE  16'hFFAE
`define DBP_IDX_PORT_CONTROL         16'hFFC0
`define DBP_IDX_PORT_STATUS          16'hFFC1

// Field positions of the control register
`define DBP_CTRL_PWM_B_BIT           0
`define DBP_CTRL_HIE_BIT             1

// Field positions of the status register
`define DBP_STAT_MODE_LSB            0
`define DBP_STAT_MODE_MSB            1
`define DBP_STAT_SW_STANDBY_BIT      2
`define DBP_STAT_HW_STANDBY_BIT      3

// Reset and fixed values
`define DBP_RESET_BYTE               8'h00
`define DBP_DIR_READBACK             8'hFF
`define DBP_MODE1_DIRECTION          8'hFF
`define DBP_UNMAPPED_READ            8'h00

// Operating mode codes on the mode pins
`define DBP_MODE_1                   2'h1
`define DBP_MODE_2                   2'h2
`define DBP_MODE_3                   2'h3

`endif

// ==== hdl/dbp_pkg.sv ====
// Types shared by the dual byte port pair modules
package dbp_pkg;

  // Avalon slave handshake state
  typedef enum logic {
    DBP_BUS_IDLE,
    DBP_BUS_ACK
  } dbp_bus_t;

  // All state of the register and mode logic
  typedef struct packed {
    dbp_bus_t    bus;
    logic        waitreq;
    logic [7:0]  rdata;
    logic [7:0]  p2_latch;
    logic [7:0]  p2_pullup;
    logic [7:0]  p2_dir;
    logic [7:0]  p3_latch;
    logic [7:0]  p3_pullup;
    logic [7:0]  p3_dir;
    logic        pwm_b;
    logic        host_interface_enable;
    logic [1:0]  mode_s1;
    logic [1:0]  mode_s2;
    logic        hws_s1;
    logic        hws_s2;
  } dbp_top_state_t;

  // All state of one pin group
  typedef struct packed {
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic [7:0]  out;
    logic [7:0]  oe;
    logic [7:0]  pull;
  } dbp_port_state_t;

endpackage : dbp_pkg

// ==== hdl/dbp_port_if.sv ====
// Signals between the register logic and one pin group
`timescale 1ns/1ns
`default_nettype none

interface dbp_port_if;
  logic [7:0] drv_en;    // Pin driver enables wanted
  logic [7:0] drv_val;   // Pin levels wanted
  logic [7:0] pull_en;   // Pull-up enables wanted
  logic [7:0] pin_sync;  // Synchronised pin levels

  modport ctrl (output drv_en, output drv_val, output pull_en, input pin_sync);
  modport pins (input drv_en, input drv_val, input pull_en, output pin_sync);
endinterface : dbp_port_if

`default_nettype wire

// ==== hdl/dbp_port.sv ====
// One 8-bit pin group: input synchroniser and registered pin drivers
`timescale 1ns/1ns
`default_nettype none

module dbp_port
  import dbp_pkg::*;
(
  input  wire logic       i_clk,      // System clock
  input  wire logic       i_resetn,   // Asynchronous reset, active low
  input  wire logic       i_ce,       // Clock enable
  dbp_port_if.pins        port,       // Towards the register logic
  input  wire logic [7:0] i_pin_in,   // Pin levels from the pads
  output logic      [7:0] o_pin_out,  // Pin output levels
  output logic      [7:0] o_pin_oe,   // Pin output enables, high drives
  output logic      [7:0] o_pullup    // Pull-up enables
);

  dbp_port_state_t st_r;
  dbp_port_state_t st_nxt;

  // Pads are asynchronous, so two stages before anyone reads them
  always_comb begin
    st_nxt = st_r;
    if (i_ce) begin
      st_nxt.sync1 = i_pin_in;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.out   = port.drv_val;
      st_nxt.oe    = port.drv_en;
      st_nxt.pull  = port.pull_en;
    end
  end

  // Pins float and pull-ups stay off while reset is held
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Only the second stage leaves the module
  assign port.pin_sync = st_r.sync2;
  assign o_pin_out     = st_r.out;
  assign o_pin_oe      = st_r.oe;
  assign o_pullup      = st_r.pull;

endmodule : dbp_port

`default_nettype wire

// ==== hdl/dbp_io_pair.sv ====
// Two byte-wide ports: registers, read-back, direction, pull-ups and pin function per mode
`timescale 1ns/1ns
`default_nettype none
`include "dbp_regs.svh"

// How it works
// - Output pins read back the port 2 latch
// - Input pins read back the port 2 pin
// - Port 2 latch clears, kept in software standby
// - Port 2 pull-up needs enable set, direction clear
// - Port 2 pull-up enables clear, kept in software standby
// - Mode 1 drives upper address on port 2
// - Mode 2: output address/PWM, else input
// - Mode 3: direction clear means general input
// - Mode 3 output: latch or PWM by group B
// - Port 2 pull-ups off in mode 1, reset, hardware standby
// - Software standby keeps pull-up state unchanged
// - Port 3 direction write-only, reads all ones
// - Port 3 direction clears, kept in software standby
// - Modes 1, 2: port 3 is data bus
// - Data bus floats in reset and standby
// - Mode 3 without slave: port 3 output or input by direction
// - Port 3 reads latch or pin by direction
// - Port 3 latch clears, kept in software standby
// - Port 3 pull-ups only in mode 3
// - Port 3 pull-up needs enable, input, no slave
// - Port 3 pull-up enables clear, kept in software standby
// - Port 2 direction write-only, ones in mode 1
module dbp_io_pair
  import dbp_pkg::*;
(
  input  wire logic        i_clk,             // System clock, 20 MHz
  input  wire logic        i_resetn,          // Asynchronous reset, active low
  input  wire logic        i_ce,              // Clock enable, freezes all state when low
  // Avalon-MM slave
  input  wire logic [15:0] i_avs_address,     // Word address, equals register index
  input  wire logic        i_avs_read,        // Read request
  input  wire logic        i_avs_write,       // Write request
  input  wire logic [31:0] i_avs_writedata,   // Write data, byte lane 0 used
  input  wire logic [3:0]  i_avs_byteenable,  // Byte enables, lane 0 must be set to write
  output logic      [31:0] o_avs_readdata,    // Read data, upper bytes zero
  output logic             o_avs_waitrequest, // High until the access completes
  // System state
  input  wire logic [1:0]  i_mode,            // Mode pins, asynchronous
  input  wire logic        i_hw_standby,      // Hardware standby pin, asynchronous
  input  wire logic        i_sw_standby,      // Software standby from the system controller
  // Sources multiplexed onto the pins
  input  wire logic [7:0]  i_addr_hi,         // Upper address bits 15 to 8
  input  wire logic [7:0]  i_pwm,             // PWM outputs for port 2
  input  wire logic [7:0]  i_dbus_wdata,      // External data bus write data
  input  wire logic        i_dbus_drive,      // External data bus drive request
  input  wire logic [7:0]  i_hdb_wdata,       // Host data bus read-back data
  input  wire logic        i_hdb_drive,       // Host data bus drive request
  output logic      [7:0]  o_p3_in,           // Synchronised port 3 levels for the bus users
  // Port 2 pads
  input  wire logic [7:0]  i_p2_pin,          // Port 2 pad levels
  output logic      [7:0]  o_p2_out,          // Port 2 output levels
  output logic      [7:0]  o_p2_oe,           // Port 2 output enables
  output logic      [7:0]  o_p2_pullup,       // Port 2 pull-up enables
  // Port 3 pads
  input  wire logic [7:0]  i_p3_pin,          // Port 3 pad levels
  output logic      [7:0]  o_p3_out,          // Port 3 output levels
  output logic      [7:0]  o_p3_oe,           // Port 3 output enables
  output logic      [7:0]  o_p3_pullup        // Port 3 pull-up enables
);

  // Whole register state lives in one struct
  dbp_top_state_t st_r;
  dbp_top_state_t st_nxt;

  // This module drives the wanted pin state and reads the pads back
  dbp_port_if p2_if ();
  dbp_port_if p3_if ();

  // Decoded operating conditions
  // All but req, commit and wbyte are plain decodes of registered state
  logic       mode1;
  logic       mode2;
  logic       mode3;
  logic       hws;
  logic       slave;
  logic [7:0] p2_dir_eff;
  logic [7:0] p2_read;
  logic [7:0] p3_read;
  logic       req;
  logic       commit;
  logic [7:0] wbyte;

  // Codes other than 1 and 2 run as single-chip mode
  // Code 0 means nothing; mode 3 keeps pins as inputs
  // Only the second synchroniser stage is decoded
  // Mode pins are expected to stay put in normal use
  // Slave mode needs single-chip mode and the host bit
  assign mode1 = (st_r.mode_s2 == `DBP_MODE_1);
  assign mode2 = (st_r.mode_s2 == `DBP_MODE_2);
  assign mode3 = !mode1 && !mode2;
  assign hws   = st_r.hws_s2;
  assign slave = mode3 && st_r.host_interface_enable;

  // Mode 1 bypasses the stored direction, not overwrites it
  // mode 1 direction
  assign p2_dir_eff = mode1 ? `DBP_MODE1_DIRECTION : st_r.p2_dir;

  // Read-back is per bit: outputs report the latch,
  // inputs the pad after two synchroniser stages.
  // A loaded output pin still reads what was written
  // latch read-back
  assign p2_read = (p2_dir_eff & st_r.p2_latch) | (~p2_dir_eff & p2_if.pin_sync);

  // In the bus modes latch and direction still exist,
  // they just do not reach the pins
  // port 3 read-back
  assign p3_read = (st_r.p3_dir & st_r.p3_latch) | (~st_r.p3_dir & p3_if.pin_sync);

  // Fixed two-cycle access: taken, then one answer cycle.
  // Only lane 0 carries data; a write with it disabled
  // completes on the bus but changes nothing
  // Bus request and the edge at which it completes
  assign req    = i_avs_read || i_avs_write;
  assign wbyte  = i_avs_writedata[7:0];
  // completing edge write
  // Ack state means the master has seen waitrequest low
  assign commit = (st_r.bus == DBP_BUS_ACK) && i_avs_write && i_avs_byteenable[0];

  // Register, handshake and synchroniser next state
  always_comb begin
    st_nxt = st_r;
    if (i_ce) begin
      // Mode and standby pins are asynchronous
      // Software standby is on this clock and needs no stages
      st_nxt.mode_s1 = i_mode;
      st_nxt.mode_s2 = st_r.mode_s1;
      st_nxt.hws_s1  = i_hw_standby;
      st_nxt.hws_s2  = st_r.hws_s1;

      // Read data are captured when the request is taken
      // One wait cycle, then a single completing cycle
      case (st_r.bus)
        DBP_BUS_IDLE: begin
          if (req) begin
            st_nxt.bus     = DBP_BUS_ACK;
            st_nxt.waitreq = 1'b0;
            st_nxt.rdata   = `DBP_UNMAPPED_READ;
            // Writes answer zero; only reads look up a register
            if (i_avs_read) begin
              case (i_avs_address)
                `DBP_IDX_PORT2_DIRECTION:     st_nxt.rdata = `DBP_DIR_READBACK;
                `DBP_IDX_PORT2_OUTPUT_LATCH:  st_nxt.rdata = p2_read;
                `DBP_IDX_PORT2_PULLUP_ENABLE: st_nxt.rdata = st_r.p2_pullup;
                `DBP_IDX_PORT3_DIRECTION:     st_nxt.rdata = `DBP_DIR_READBACK;
                `DBP_IDX_PORT3_OUTPUT_LATCH:  st_nxt.rdata = p3_read;
                `DBP_IDX_PORT3_PULLUP_ENABLE: st_nxt.rdata = st_r.p3_pullup;
                `DBP_IDX_PORT_CONTROL: begin
                  st_nxt.rdata[`DBP_CTRL_PWM_B_BIT] = st_r.pwm_b;
                  st_nxt.rdata[`DBP_CTRL_HIE_BIT]   = st_r.host_interface_enable;
                end
                `DBP_IDX_PORT_STATUS: begin
                  st_nxt.rdata[`DBP_STAT_MODE_MSB:`DBP_STAT_MODE_LSB] = st_r.mode_s2;
                  st_nxt.rdata[`DBP_STAT_SW_STANDBY_BIT] = i_sw_standby;
                  st_nxt.rdata[`DBP_STAT_HW_STANDBY_BIT] = hws;
                end
                default: st_nxt.rdata = `DBP_UNMAPPED_READ;
              endcase
            end
          end
        end
        DBP_BUS_ACK: begin
          // The master drops its request after this cycle
          st_nxt.bus     = DBP_BUS_IDLE;
          st_nxt.waitreq = 1'b1;
        end
        default: begin
          // Unreachable with a two-state enum; safe return
          st_nxt.bus     = DBP_BUS_IDLE;
          st_nxt.waitreq = 1'b1;
        end
      endcase

      // Writes land on the edge that ends the answer cycle
      // Register writes; unmapped indices are dropped silently
      if (commit) begin
        case (i_avs_address)
          `DBP_IDX_PORT2_DIRECTION:     st_nxt.p2_dir    = wbyte;
          `DBP_IDX_PORT2_OUTPUT_LATCH:  st_nxt.p2_latch  = wbyte;
          `DBP_IDX_PORT2_PULLUP_ENABLE: st_nxt.p2_pullup = wbyte;
          `DBP_IDX_PORT3_DIRECTION:     st_nxt.p3_dir    = wbyte;
          `DBP_IDX_PORT3_OUTPUT_LATCH:  st_nxt.p3_latch  = wbyte;
          `DBP_IDX_PORT3_PULLUP_ENABLE: st_nxt.p3_pullup = wbyte;
          `DBP_IDX_PORT_CONTROL: begin
            st_nxt.pwm_b = wbyte[`DBP_CTRL_PWM_B_BIT];
            st_nxt.host_interface_enable   = wbyte[`DBP_CTRL_HIE_BIT];
          end
          default: begin
          end
        endcase
      end

      // Hardware standby overrides any latch, direction or pull-up write in the same cycle;
      // software standby simply leaves every register alone
      // Control bits are cleared only by the reset input
      if (hws) begin
        st_nxt.p2_latch  = `DBP_RESET_BYTE;
        st_nxt.p2_pullup = `DBP_RESET_BYTE;
        st_nxt.p2_dir    = `DBP_RESET_BYTE;
        st_nxt.p3_latch  = `DBP_RESET_BYTE;
        st_nxt.p3_pullup = `DBP_RESET_BYTE;
        st_nxt.p3_dir    = `DBP_RESET_BYTE;
      end
    end
  end

  // Mode stages reset to mode 3, so pins come up as inputs
  // before the real mode pins have been synchronised
  // Bus state starts idle with waitrequest high
  // All control state comes out of reset at its documented value
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r         <= '0;
      st_r.bus     <= DBP_BUS_IDLE;
      st_r.waitreq <= 1'b1;
      st_r.mode_s1 <= `DBP_MODE_3;
      st_r.mode_s2 <= `DBP_MODE_3;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Software standby does not appear here: outputs keep
  // driving and pull-ups keep their state.
  // Hardware standby floats the pins like the address bus
  // Pin registers add one edge after the control change
  // Port 2 pin function per mode
  always_comb begin
    p2_if.drv_en  = 8'h00;
    p2_if.drv_val = 8'h00;
    p2_if.pull_en = 8'h00;
    if (hws) begin
      // Address bus and general pins all float in hardware standby
      p2_if.drv_en  = 8'h00;
    end else if (mode1) begin
      // upper address out
      // Direction and pull-up registers are bypassed here
      p2_if.drv_en  = 8'hFF;
      p2_if.drv_val = i_addr_hi;
    end else if (mode2) begin
      // address or PWM
      // Group B picks PWM over address for every pin
      p2_if.drv_en  = st_r.p2_dir;
      p2_if.drv_val = st_r.pwm_b ? i_pwm : i_addr_hi;
    end else begin
      p2_if.drv_en  = st_r.p2_dir;
      // latch or PWM
      // Group B selects PWM, otherwise the latch drives
      p2_if.drv_val = st_r.pwm_b ? i_pwm : st_r.p2_latch;
    end
    // held through software standby
    // Pull-ups share the registered path of the drivers
    if (!hws && !mode1) begin
      p2_if.pull_en = st_r.p2_pullup & ~p2_dir_eff;
    end
  end

  // The data bus drives only on request and outside standby;
  // in single-chip mode software standby keeps the outputs.
  // Slave mode leaves latch and direction untouched
  // Port 3 pin function per mode
  always_comb begin
    p3_if.drv_en  = 8'h00;
    p3_if.drv_val = 8'h00;
    p3_if.pull_en = 8'h00;
    if (hws) begin
      // float in hardware standby
      // Bus and host drive requests are ignored here
      p3_if.drv_en  = 8'h00;
    end else if (!mode3) begin
      // float in software standby
      // The stored direction is ignored here
      p3_if.drv_en  = (i_dbus_drive && !i_sw_standby) ? 8'hFF : 8'h00;
      p3_if.drv_val = i_dbus_wdata;
    end else if (slave) begin
      // Host data bus owns the pins in slave mode
      // Host side decides when to drive
      p3_if.drv_en  = i_hdb_drive ? 8'hFF : 8'h00;
      p3_if.drv_val = i_hdb_wdata;
    end else begin
      p3_if.drv_en  = st_r.p3_dir;
      p3_if.drv_val = st_r.p3_latch;
    end
    // input and not slave
    // Direction 0 with control bit 1 turns it on
    if (!hws && mode3 && !slave) begin
      p3_if.pull_en = st_r.p3_pullup & ~st_r.p3_dir;
    end
  end

  // Each group owns its synchroniser and output registers,
  // so both ports see the same input and output lag
  // Pin group for port 2
  dbp_port u_port2 (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_ce      (i_ce),
    .port      (p2_if),
    .i_pin_in  (i_p2_pin),
    .o_pin_out (o_p2_out),
    .o_pin_oe  (o_p2_oe),
    .o_pullup  (o_p2_pullup)
  );

  // Pin group for port 3
  dbp_port u_port3 (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_ce      (i_ce),
    .port      (p3_if),
    .i_pin_in  (i_p3_pin),
    .o_pin_out (o_p3_out),
    .o_pin_oe  (o_p3_oe),
    .o_pullup  (o_p3_pullup)
  );

  // Bus outputs straight from the state register; the bus users see
  // port 3 through the same synchroniser, so reads lag the pads by two edges
  // Upper read data bytes are tied low
  assign o_avs_readdata    = {24'h000000, st_r.rdata};
  assign o_avs_waitrequest = st_r.waitreq;
  assign o_p3_in           = p3_if.pin_sync;

endmodule : dbp_io_pair

`default_nettype wire

// ==== testbench/dbp_io_pair_props.sv ====
// Concurrent checks on the top ports of the dual byte port pair
`timescale 1ns/1ns
`default_nettype none

module dbp_io_pair_props (
  input wire logic        i_clk,             // Clock
  input wire logic        i_resetn,          // Reset, active low
  input wire logic        i_ce,              // Clock enable
  input wire logic        i_avs_read,        // Read request
  input wire logic        i_avs_write,       // Write request
  input wire logic [31:0] o_avs_readdata,    // Read data
  input wire logic        o_avs_waitrequest, // Wait request
  input wire logic [1:0]  i_mode,            // Mode pins
  input wire logic        i_hw_standby,      // Hardware standby
  input wire logic        i_sw_standby,      // Software standby
  input wire logic [7:0]  i_addr_hi,         // Upper address source
  input wire logic [7:0]  o_p2_out,          // Port 2 levels
  input wire logic [7:0]  o_p2_oe,           // Port 2 enables
  input wire logic [7:0]  o_p2_pullup,       // Port 2 pull-ups
  input wire logic [7:0]  o_p3_oe,           // Port 3 enables
  input wire logic [7:0]  o_p3_pullup        // Port 3 pull-ups
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // Access steps: taken while idle, then exactly one answer cycle
  sequence s_taken;
    (i_avs_read || i_avs_write) && o_avs_waitrequest && i_ce;
  endsequence
  sequence s_answer;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence

  // Mode pins pass two sync flops and a pin register, so four steady cycles
  a_bus_answer: assert property (s_taken |=> s_answer)
    else $error("bus access not answered in one cycle");
  a_rdata_upper: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bytes not zero");
  a_pull_not_driven: assert property (((o_p2_pullup & o_p2_oe) | (o_p3_pullup & o_p3_oe)) == 8'h00)
    else $error("pull-up on a driven pin");
  a_m1_pull_off: assert property ((i_mode == 2'h1)[*4] |-> o_p2_pullup == 8'h00)
    else $error("port 2 pull-up on in mode 1");
  a_m1_addr_drive: assert property ((i_mode == 2'h1 && !i_hw_standby && i_ce)[*4]
    |=> o_p2_oe == 8'hFF && o_p2_out == $past(i_addr_hi))
    else $error("port 2 not driving upper address");
  a_dbus_sws_float: assert property ((^i_mode && i_sw_standby && i_ce)[*4] |=> o_p3_oe == 8'h00)
    else $error("data bus driven in software standby");
  a_hws_float: assert property ((i_hw_standby && i_ce)[*4]
    |=> (o_p2_oe | o_p3_oe | o_p2_pullup | o_p3_pullup) == 8'h00)
    else $error("pins active in hardware standby");
  a_p3_pull_mode: assert property ((^i_mode)[*4] |-> o_p3_pullup == 8'h00)
    else $error("port 3 pull-up outside mode 3");
endmodule : dbp_io_pair_props

bind dbp_io_pair dbp_io_pair_props dbp_io_pair_props_inst (.i_clk, .i_resetn, .i_ce, .i_avs_read,
  .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .i_mode, .i_hw_standby, .i_sw_standby,
  .i_addr_hi, .o_p2_out, .o_p2_oe, .o_p2_pullup, .o_p3_oe, .o_p3_pullup);

`default_nettype wire

// ==== testbench/dbp_pad_model.sv ====
// Pad model: resolves each pin from the block, an outside driver and the pull-up
`timescale 1ns/1ns
`default_nettype none

module dbp_pad_model (
  input  wire logic       i_clk,     // Clock for the floating pattern
  input  wire logic [7:0] i_out,     // Block output levels
  input  wire logic [7:0] i_oe,      // Block output enables
  input  wire logic [7:0] i_pullup,  // Block pull-up enables
  input  wire logic [7:0] i_ext,     // Outside driver levels
  input  wire logic [7:0] i_ext_en,  // Outside driver enables
  output logic      [7:0] o_pin      // Resolved pad levels
);
  logic [7:0] float_r = 8'h55;  // Undriven pins wander so a stale level never passes

  // Pattern changes every cycle
  always_ff @(posedge i_clk) begin
    float_r <= ~float_r;
  end

  // Block driver wins, then outside driver, then pull-up, else floating
  always_comb begin
    o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext) | (~i_oe & ~i_ext_en & (i_pullup | float_r));
  end
endmodule : dbp_pad_model

`default_nettype wire

// ==== testbench/tb.sv ====
// Register-level testbench of the dual byte port pair
`timescale 1ns/1ns
`default_nettype none
`include "dbp_regs.svh"

module tb;
  logic        i_clk = 1'h0, i_resetn = 1'h0, i_ce = 1'h1;       // Clock, reset, enable
  logic        i_avs_read = 1'h0, i_avs_write = 1'h0;            // Bus strobes
  logic [15:0] i_avs_address = 16'h0000;                         // Register index
  logic [31:0] i_avs_writedata = 32'h00000000;                   // Write data
  logic [3:0]  i_avs_byteenable = 4'hF;                          // Byte enables
  logic [1:0]  i_mode = 2'h3;                                    // Mode pins
  logic        i_hw_standby = 1'h0, i_sw_standby = 1'h0;         // Standby inputs
  logic [7:0]  i_addr_hi = 8'h00, i_pwm = 8'h00;                 // Port 2 sources
  logic [7:0]  i_dbus_wdata = 8'h00, i_hdb_wdata = 8'h00;        // Port 3 sources
  logic        i_dbus_drive = 1'h0, i_hdb_drive = 1'h0;          // Port 3 drive requests
  logic [7:0]  e2 = 8'hA5, e3 = 8'h5A, e2_en = 8'hFF;            // Outside pin drivers
  logic [7:0]  i_p2_pin, i_p3_pin, o_p2_out, o_p2_oe, o_p2_pullup;
  logic [7:0]  o_p3_out, o_p3_oe, o_p3_pullup, o_p3_in;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  int          n_errors = 0, checks = 0;

  always #25 i_clk = ~i_clk;

  dbp_io_pair dbp_io_pair_inst (.i_clk, .i_resetn, .i_ce, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_mode, .i_hw_standby,
    .i_sw_standby, .i_addr_hi, .i_pwm, .i_dbus_wdata, .i_dbus_drive, .i_hdb_wdata, .i_hdb_drive,
    .o_p3_in, .i_p2_pin, .o_p2_out, .o_p2_oe, .o_p2_pullup, .i_p3_pin, .o_p3_out, .o_p3_oe, .o_p3_pullup);
  dbp_pad_model p2_pads (.i_clk, .i_out(o_p2_out), .i_oe(o_p2_oe), .i_pullup(o_p2_pullup),
    .i_ext(e2), .i_ext_en(e2_en), .o_pin(i_p2_pin));
  dbp_pad_model p3_pads (.i_clk, .i_out(o_p3_out), .i_oe(o_p3_oe), .i_pullup(o_p3_pullup),
    .i_ext(e3), .i_ext_en(8'hFF), .o_pin(i_p3_pin));

  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One Avalon access; the request holds until waitrequest is seen low
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_address <= idx;
    i_avs_writedata <= {24'h000000, wd};
    i_avs_write <= wr;
    i_avs_read <= !wr;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'h0 && n < 20);
    rd = o_avs_readdata[7:0];
    i_avs_write <= 1'h0;
    i_avs_read <= 1'h0;
    if (n >= 20) begin
      n_errors++;
      $display("[ERR] bus answer expected 0 seen 1");
      stop_test();
    end
  endtask : bus

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'h1, idx, d, x);
  endtask : wr

  task automatic rdc(input string what, input logic [15:0] idx, input logic [7:0] exp);
    logic [7:0] x;
    bus(1'h0, idx, 8'h00, x);
    chk(what, x, exp);
  endtask : rdc

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc

  // Main sequence, mode 3 first, then modes 2 and 1
  initial begin
    cyc(5);
    i_resetn <= 1'h1;
    cyc(4);
    rdc("p2 dir", `DBP_IDX_PORT2_DIRECTION, 8'hFF);
    rdc("p3 dir", `DBP_IDX_PORT3_DIRECTION, 8'hFF);
    rdc("p2 pull reg", `DBP_IDX_PORT2_PULLUP_ENABLE, 8'h00);
    rdc("p3 pull reg", `DBP_IDX_PORT3_PULLUP_ENABLE, 8'h00);
    chk("p2 oe", o_p2_oe, 8'h00);
    rdc("p2 in", `DBP_IDX_PORT2_OUTPUT_LATCH, 8'hA5);
    wr(`DBP_IDX_PORT2_OUTPUT_LATCH, 8'h3C);
    wr(`DBP_IDX_PORT2_DIRECTION, 8'hF0);
    wr(`DBP_IDX_PORT3_OUTPUT_LATCH, 8'hC3);
    wr(`DBP_IDX_PORT3_DIRECTION, 8'h0F);
    wr(`DBP_IDX_PORT2_PULLUP_ENABLE, 8'hFF);
    wr(`DBP_IDX_PORT3_PULLUP_ENABLE, 8'hFF);
    cyc(2);
    rdc("p2 mix", `DBP_IDX_PORT2_OUTPUT_LATCH, 8'h35);
    rdc("p3 mix", `DBP_IDX_PORT3_OUTPUT_LATCH, 8'h53);
    chk("p2 oe", o_p2_oe, 8'hF0);
    chk("p2 out", o_p2_out & 8'hF0, 8'h30);
    chk("p3 oe", o_p3_oe, 8'h0F);
    chk("p3 out", o_p3_out & 8'h0F, 8'h03);
    chk("p2 pull", o_p2_pullup, 8'h0F);
    chk("p3 pull", o_p3_pullup, 8'hF0);
    e2_en <= 8'h00;
    cyc(3);
    rdc("p2 pulled", `DBP_IDX_PORT2_OUTPUT_LATCH, 8'h3F);
    e2_en <= 8'hFF;
    wr(8'h00 | `DBP_IDX_PORT_CONTROL, 8'h03);
    i_pwm <= 8'h96;
    i_hdb_drive <= 1'h1;
    i_hdb_wdata <= 8'h69;
    cyc(3);
    chk("p2 pwm", o_p2_out & 8'hF0, 8'h90);
    chk("slave pull", o_p3_pullup, 8'h00);
    chk("slave out", o_p3_out & o_p3_oe, 8'h69);
    rdc("ctrl", `DBP_IDX_PORT_CONTROL, 8'h03);
    wr(`DBP_IDX_PORT_CONTROL, 8'h00);
    i_hdb_drive <= 1'h0;
    i_sw_standby <= 1'h1;
    cyc(4);
    chk("sws p2 pull", o_p2_pullup, 8'h0F);
    chk("sws p3 oe", o_p3_oe, 8'h0F);
    chk("sws p2 out", o_p2_out & 8'hF0, 8'h30);
    i_sw_standby <= 1'h0;
    $display("test mode 3 done");
    i_hw_standby <= 1'h1;
    cyc(6);
    i_hw_standby <= 1'h0;
    cyc(4);
    rdc("hws p2 pull", `DBP_IDX_PORT2_PULLUP_ENABLE, 8'h00);
    rdc("hws p3 pull", `DBP_IDX_PORT3_PULLUP_ENABLE, 8'h00);
    chk("hws p3 oe", o_p3_oe, 8'h00);
    wr(`DBP_IDX_PORT2_DIRECTION, 8'hFF);
    wr(`DBP_IDX_PORT3_DIRECTION, 8'hFF);
    rdc("hws p2 latch", `DBP_IDX_PORT2_OUTPUT_LATCH, 8'h00);
    i_avs_byteenable <= 4'hE;
    wr(`DBP_IDX_PORT3_OUTPUT_LATCH, 8'hFF);
    i_avs_byteenable <= 4'hF;
    rdc("hws p3 latch", `DBP_IDX_PORT3_OUTPUT_LATCH, 8'h00);
    rdc("unmapped", 16'h0000, 8'h00);
    $display("test standby done");
    i_mode <= 2'h2;
    i_addr_hi <= 8'h7E;
    i_dbus_drive <= 1'h1;
    i_dbus_wdata <= 8'h81;
    cyc(5);
    wr(`DBP_IDX_PORT2_DIRECTION, 8'h0F);
    wr(`DBP_IDX_PORT2_PULLUP_ENABLE, 8'hFF);
    wr(`DBP_IDX_PORT3_DIRECTION, 8'h00);
    wr(`DBP_IDX_PORT3_PULLUP_ENABLE, 8'hFF);
    cyc(2);
    chk("m2 p2 oe", o_p2_oe, 8'h0F);
    chk("m2 p2 out", o_p2_out & 8'h0F, 8'h0E);
    chk("m2 p2 pull", o_p2_pullup, 8'hF0);
    chk("m2 p3 oe", o_p3_oe, 8'hFF);
    chk("m2 p3 out", o_p3_out, 8'h81);
    chk("m2 p3 pull", o_p3_pullup, 8'h00);
    i_sw_standby <= 1'h1;
    cyc(4);
    chk("m2 sws p3 oe", o_p3_oe, 8'h00);
    i_sw_standby <= 1'h0;
    $display("test mode 2 done");
    i_mode <= 2'h1;
    cyc(5);
    chk("m1 p2 oe", o_p2_oe, 8'hFF);
    chk("m1 p2 out", o_p2_out, 8'h7E);
    chk("m1 p2 pull", o_p2_pullup, 8'h00);
    rdc("m1 p2 dir", `DBP_IDX_PORT2_DIRECTION, 8'hFF);
    chk("m1 p3 in", o_p3_in, 8'h81);
    rdc("m1 status", `DBP_IDX_PORT_STATUS, 8'h01);
    i_ce <= 1'h0;
    i_addr_hi <= 8'h18;
    cyc(3);
    chk("ce hold", o_p2_out, 8'h7E);
    i_ce <= 1'h1;
    cyc(3);
    chk("ce run", o_p2_out, 8'h18);
    $display("test mode 1 done");
    stop_test();
  end
endmodule : tb

`default_nettype wire
